/* File: verilog/pss_regs.svh */
// register map, reset values, field positions and timing of the strap and management block
`ifndef PSS_REGS_SVH
`define PSS_REGS_SVH
`define PSS_REG_CTRL 5'h00
`define PSS_REG_STAT 5'h01
`define PSS_REG_IDH 5'h02
`define PSS_REG_IDL 5'h03
`define PSS_REG_ADV 5'h04
`define PSS_REG_LPA 5'h05
`define PSS_REG_EXP 5'h06
`define PSS_CTRL_RST 16'h3100
`define PSS_STAT_RST 16'h7849
`define PSS_ADV_RST 16'h01e1
`define PSS_LPA_RST 16'h0080
`define PSS_EXP_RST 16'h0000
`define PSS_CTRL_LOOP 14
`define PSS_CTRL_SPD 13
`define PSS_CTRL_ANE 12
`define PSS_CTRL_PD 11
`define PSS_CTRL_ISO 10
`define PSS_CTRL_DUP 8
`define PSS_AB_100FD 8
`define PSS_AB_100HD 7
`define PSS_AB_10FD 6
`define PSS_OP_READ 2'h2
`define PSS_OP_WRITE 2'h1
`define PSS_HDR_BITS 5'h0d
`define PSS_DATA_BITS 5'h10
`define PSS_STRAP_SETTLE 2'h3
`define PSS_CLK_MHZ 10
`define PSS_XTAL_MHZ 25
`define PSS_SW_RESET_NS 1000
`define PSS_SW_RESET_CYC 4'((`PSS_SW_RESET_NS * `PSS_CLK_MHZ + 999) / 1000)
`endif

/* File: verilog/pss_pkg.sv */
// types shared by the strap and management block
package pss_pkg;
  typedef enum logic [2:0] {
    MD_IDLE, MD_HDR, MD_RTA, MD_RDATA, MD_WTA, MD_WDATA
  } pss_mstate_t;

  typedef struct packed {
    logic       mdc;
    logic       mdio;
    logic       txen;
    logic       txd;
    logic       rx;
    logic       carrier;
    logic [4:0] led;
    logic       test;
    logic       iso;
    logic       rptr;
    logic       spd;
    logic       dup;
    logic       autoneg_strap;
    logic       link_down_power_save_strap;
    logic       ifsel;
  } pss_pins_t;

  typedef struct packed {
    logic test;
    logic rptr;
    logic spd;
    logic dup;
    logic autoneg_strap;
    logic link_down_power_save_strap;
    logic ifsel;
  } pss_strap_t;

  typedef struct packed {
    pss_pins_t   s1;
    pss_pins_t   s2;
    logic        mdc_prev;
    logic [1:0]  boot_cnt;
    logic        booted;
    pss_strap_t  strap;
    logic [4:0]  phy_addr;
    logic [15:0] ctrl;
    logic [15:0] adv;
    logic [3:0]  rst_cnt;
    pss_mstate_t mst;
    logic [4:0]  cnt;
    logic [12:0] hdr;
    logic [15:0] shift;
    logic        mdio_o;
    logic        mdio_oe;
    logic [6:0]  txdiv;
    logic        txc;
    logic        tx_bit;
    logic        tx_en;
    logic [6:0]  rxph;
    logic        rx_prev;
    logic        rxc;
    logic        rxd;
    logic        crs;
    logic        col;
    logic [4:0]  led;
    logic [4:0]  led_oe;
    logic        spd100;
    logic        fdx;
    logic        autoneg_strap;
    logic        rptr;
    logic        psave;
    logic        minp;
    logic        nib;
    logic        spare;
  } pss_state_t;
endpackage

/* File: verilog/pss_top.sv */
// strap capture, management registers, serial data interface and LEDs
`timescale 1ns/1ps
`include "pss_regs.svh"
module pss_top #(
  parameter int          TXC_HALF_CYC = 2,
  parameter logic [15:0] ID_HIGH      = 16'h1234, // arbitrary value
  parameter logic [15:0] ID_LOW       = 16'h5678  // arbitrary value
) (
  // clock and chip reset
  input  wire logic       SYS_CLK_IN,
  input  wire logic       RST_B_IN,
  // configuration straps
  input  wire logic       ISOLATE_STRAP_IN,
  input  wire logic       REPEATER_STRAP_IN,
  input  wire logic       SPEED_STRAP_IN,
  input  wire logic       DUPLEX_STRAP_IN,
  input  wire logic       AUTONEG_STRAP_IN,
  input  wire logic       LINK_DOWN_POWER_SAVE_STRAP_IN,
  input  wire logic       INTERFACE_SELECT_STRAP_IN,
  input  wire logic       TEST_MODE_IN,
  // management interface
  input  wire logic       MDC_IN,
  input  wire logic       MDIO_IN,
  output logic            MDIO_OUT,
  output logic            MDIO_OE_OUT,
  // serial network interface
  output logic            TXC_OUT,
  input  wire logic       TXEN_IN,
  input  wire logic       TXD0_IN,
  output logic            RXC_OUT,
  output logic            RXD0_OUT,
  output logic            CRS_OUT,
  output logic            COL_OUT,
  // line side
  input  wire logic       LINE_RX_IN,
  input  wire logic       LINE_CARRIER_IN,
  output logic            LINE_TX_OUT,
  output logic            LINE_TX_EN_OUT,
  // LEDs and address straps
  input  wire logic [4:0] LED_IN,
  output logic      [4:0] LED_OUT,
  output logic      [4:0] LED_OE_OUT,
  // operating mode
  output logic            SPEED_100_OUT,
  output logic            FULL_DUPLEX_OUT,
  output logic            AUTONEG_OUT,
  output logic            REPEATER_MODE_OUT,
  output logic            POWER_SAVE_OUT,
  output logic            MIN_POWER_OUT,
  output logic            NIBBLE_MODE_OUT,
  output logic            SPARE_TEST_OUT
);
  generate
    if (TXC_HALF_CYC < 1 || TXC_HALF_CYC > 63)
    begin : g_chk
      $error("TXC_HALF_CYC out of range");
    end
  endgenerate

  localparam logic [6:0] HALF_M1 = 7'(TXC_HALF_CYC - 1);
  localparam logic [6:0] FULL_M1 = 7'(2 * TXC_HALF_CYC - 1);

  pss_pkg::pss_state_t st_reg;
  pss_pkg::pss_state_t st_next;
  pss_pkg::pss_pins_t  raw;
  logic [15:0]         common;
  logic [15:0]         rd_data;
  logic                isolated;
  logic                an_on;
  logic                spd100;
  logic                fdx;
  logic                sni_on;
  logic                mdc_rise;
  logic                rx_src;
  logic                carrier;

  function automatic logic [15:0] ctrl_dflt(input pss_pkg::pss_strap_t s);
    logic [15:0] v;
    v = `PSS_CTRL_RST;
    v[`PSS_CTRL_SPD] = s.spd;
    v[`PSS_CTRL_ANE] = s.autoneg_strap;
    v[`PSS_CTRL_DUP] = s.dup;
    return v;
  endfunction

  assign raw = '{mdc: MDC_IN, mdio: MDIO_IN, txen: TXEN_IN, txd: TXD0_IN,
                 rx: LINE_RX_IN, carrier: LINE_CARRIER_IN, led: LED_IN,
                 test: TEST_MODE_IN, iso: ISOLATE_STRAP_IN,
                 rptr: REPEATER_STRAP_IN, spd: SPEED_STRAP_IN,
                 dup: DUPLEX_STRAP_IN, autoneg_strap: AUTONEG_STRAP_IN,
                 link_down_power_save_strap: LINK_DOWN_POWER_SAVE_STRAP_IN,
                 ifsel: INTERFACE_SELECT_STRAP_IN};

  // isolate strap acts live, control bits add to it
  assign isolated = st_reg.s2.iso | st_reg.ctrl[`PSS_CTRL_ISO]
                  | st_reg.ctrl[`PSS_CTRL_PD];
  assign an_on    = st_reg.ctrl[`PSS_CTRL_ANE];
  assign common   = st_reg.adv & `PSS_LPA_RST;
  assign spd100   = an_on ? (common[`PSS_AB_100FD] | common[`PSS_AB_100HD])
                          : st_reg.ctrl[`PSS_CTRL_SPD];
  assign fdx      = an_on ? (common[`PSS_AB_100FD] | common[`PSS_AB_10FD])
                          : st_reg.ctrl[`PSS_CTRL_DUP];
  assign sni_on   = st_reg.booted & ~st_reg.strap.ifsel & ~isolated
                  & ~spd100;
  assign mdc_rise = st_reg.s2.mdc & ~st_reg.mdc_prev;
  assign rx_src   = st_reg.ctrl[`PSS_CTRL_LOOP] ? st_reg.tx_bit : st_reg.s2.rx;
  assign carrier  = st_reg.ctrl[`PSS_CTRL_LOOP] ? st_reg.tx_en
                                                : st_reg.s2.carrier;

  always_comb
  begin
    case (st_reg.hdr[4:0])
      `PSS_REG_CTRL: rd_data = st_reg.ctrl;
      `PSS_REG_STAT: rd_data = `PSS_STAT_RST;
      `PSS_REG_IDH:  rd_data = ID_HIGH;
      `PSS_REG_IDL:  rd_data = ID_LOW;
      `PSS_REG_ADV:  rd_data = st_reg.adv;
      `PSS_REG_LPA:  rd_data = `PSS_LPA_RST;
      `PSS_REG_EXP:  rd_data = `PSS_EXP_RST;
      default:       rd_data = 16'h0000;
    endcase
  end

  always_comb
  begin
    logic [12:0] nh;
    logic [15:0] w;
    nh = {st_reg.hdr[11:0], st_reg.s2.mdio};
    w  = {st_reg.shift[14:0], st_reg.s2.mdio};
    st_next = st_reg;
    st_next.s1 = raw;
    st_next.s2 = st_reg.s1;
    st_next.mdc_prev = st_reg.s2.mdc;
    // strap capture once the synchronisers have filled
    if (!st_reg.booted)
    begin
      st_next.boot_cnt = st_reg.boot_cnt + 2'h1;
      if (st_reg.boot_cnt == `PSS_STRAP_SETTLE)
      begin
        st_next.booted   = 1'b1;
        st_next.strap    = '{test: st_reg.s2.test, rptr: st_reg.s2.rptr,
                             spd: st_reg.s2.spd, dup: st_reg.s2.dup,
                             autoneg_strap: st_reg.s2.autoneg_strap, link_down_power_save_strap: st_reg.s2.link_down_power_save_strap,
                             ifsel: st_reg.s2.ifsel};
        st_next.phy_addr = st_reg.s2.led;
        st_next.ctrl     = ctrl_dflt(st_next.strap);
      end
    end
    if (st_reg.rst_cnt != 4'h0)
    begin
      st_next.rst_cnt = st_reg.rst_cnt - 4'h1;
    end
    // management frames
    if (isolated || !st_reg.booted)
    begin
      st_next.mst     = pss_pkg::MD_IDLE;
      st_next.mdio_oe = 1'b0;
      st_next.cnt     = 5'h00;
    end
    else if (mdc_rise)
    begin
      case (st_reg.mst)
        pss_pkg::MD_IDLE:
        begin
          if (st_reg.s2.mdio)
          begin
            st_next.cnt = 5'h01;
          end
          else
          begin
            if (st_reg.cnt != 5'h00)
            begin
              st_next.mst = pss_pkg::MD_HDR;
            end
            st_next.cnt = 5'h00;
          end
        end
        pss_pkg::MD_HDR:
        begin
          st_next.hdr = nh;
          st_next.cnt = st_reg.cnt + 5'h01;
          if (st_reg.cnt == `PSS_HDR_BITS - 5'h01)
          begin
            st_next.cnt = 5'h00;
            st_next.mst = pss_pkg::MD_IDLE;
            if (nh[12] && nh[9:5] == st_reg.phy_addr)
            begin
              if (nh[11:10] == `PSS_OP_READ)
              begin
                st_next.mst = pss_pkg::MD_RTA;
              end
              else if (nh[11:10] == `PSS_OP_WRITE)
              begin
                st_next.mst = pss_pkg::MD_WTA;
              end
            end
          end
        end
        pss_pkg::MD_RTA:
        begin
          st_next.mdio_oe = 1'b1;
          st_next.mdio_o  = 1'b0;
          st_next.shift   = rd_data;
          st_next.mst     = pss_pkg::MD_RDATA;
        end
        pss_pkg::MD_RDATA:
        begin
          if (st_reg.cnt == `PSS_DATA_BITS)
          begin
            st_next.mdio_oe = 1'b0;
            st_next.mst     = pss_pkg::MD_IDLE;
            st_next.cnt     = 5'h00;
          end
          else
          begin
            st_next.mdio_o = st_reg.shift[15];
            st_next.shift  = {st_reg.shift[14:0], 1'b0};
            st_next.cnt    = st_reg.cnt + 5'h01;
          end
        end
        pss_pkg::MD_WTA:
        begin
          st_next.cnt = st_reg.cnt + 5'h01;
          if (st_reg.cnt == 5'h01)
          begin
            st_next.cnt = 5'h00;
            st_next.mst = pss_pkg::MD_WDATA;
          end
        end
        pss_pkg::MD_WDATA:
        begin
          st_next.shift = w;
          st_next.cnt   = st_reg.cnt + 5'h01;
          if (st_reg.cnt == `PSS_DATA_BITS - 5'h01)
          begin
            st_next.cnt = 5'h00;
            st_next.mst = pss_pkg::MD_IDLE;
            if (st_reg.hdr[4:0] == `PSS_REG_CTRL && st_reg.rst_cnt == 4'h0)
            begin
              if (w[15])
              begin
                st_next.ctrl    = ctrl_dflt(st_reg.strap);
                st_next.adv     = `PSS_ADV_RST;
                st_next.rst_cnt = `PSS_SW_RESET_CYC;
              end
              else
              begin
                st_next.ctrl = {1'b0, w[14:13], w[12] & st_reg.strap.autoneg_strap,
                                w[11:10], 1'b0, w[8], 8'h00};
              end
            end
            else if (st_reg.hdr[4:0] == `PSS_REG_ADV)
            begin
              st_next.adv = w;
            end
          end
        end
        default:
        begin
          st_next.mst = pss_pkg::MD_IDLE;
        end
      endcase
    end
    // transmit clock divided from the system clock
    if (st_reg.txdiv == HALF_M1)
    begin
      st_next.txdiv = 7'h00;
      st_next.txc   = ~st_reg.txc & sni_on;
      if (!st_reg.txc)
      begin
        st_next.tx_en  = st_reg.s2.txen & sni_on;
        st_next.tx_bit = st_reg.s2.txd & sni_on;
      end
    end
    else
    begin
      st_next.txdiv = st_reg.txdiv + 7'h01;
    end
    // receive clock recovered from line transitions
    st_next.rx_prev = rx_src;
    if (rx_src != st_reg.rx_prev)
    begin
      st_next.rxph = 7'h00;
      st_next.rxc  = 1'b0;
    end
    else
    begin
      st_next.rxph = (st_reg.rxph == FULL_M1) ? 7'h00 : st_reg.rxph + 7'h01;
      if (st_reg.rxph == HALF_M1)
      begin
        st_next.rxc = sni_on;
        st_next.rxd = rx_src & carrier & sni_on;
      end
      else if (st_reg.rxph == FULL_M1)
      begin
        st_next.rxc = 1'b0;
      end
    end
    st_next.crs    = carrier & sni_on;
    st_next.col    = carrier & st_reg.tx_en & ~fdx & sni_on;
    st_next.tx_en  = st_next.tx_en & sni_on;
    st_next.led_oe = st_reg.booted ? 5'h1f : 5'h00;
    st_next.led    = {st_next.col,
                      spd100 & (carrier | st_reg.tx_en),
                      ~spd100 & (carrier | st_reg.tx_en),
                      fdx, ~isolated};
    st_next.spd100 = spd100;
    st_next.fdx    = fdx;
    st_next.autoneg_strap    = an_on;
    st_next.rptr   = st_reg.strap.rptr & ~st_reg.strap.test;
    st_next.spare  = st_reg.strap.rptr & st_reg.strap.test;
    st_next.psave  = st_reg.strap.link_down_power_save_strap & ~carrier;
    st_next.minp   = isolated;
    st_next.nib    = st_reg.strap.ifsel;
  end

  always_ff @(posedge SYS_CLK_IN or negedge RST_B_IN)
  begin
    if (!RST_B_IN)
    begin
      st_reg      <= '0;
      st_reg.ctrl <= `PSS_CTRL_RST;
      st_reg.adv  <= `PSS_ADV_RST;
      st_reg.mst  <= pss_pkg::MD_IDLE;
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  assign MDIO_OUT          = st_reg.mdio_o;
  assign MDIO_OE_OUT       = st_reg.mdio_oe;
  assign TXC_OUT           = st_reg.txc;
  assign RXC_OUT           = st_reg.rxc;
  assign RXD0_OUT          = st_reg.rxd;
  assign CRS_OUT           = st_reg.crs;
  assign COL_OUT           = st_reg.col;
  assign LINE_TX_OUT       = st_reg.tx_bit;
  assign LINE_TX_EN_OUT    = st_reg.tx_en;
  assign LED_OUT           = st_reg.led;
  assign LED_OE_OUT        = st_reg.led_oe;
  assign SPEED_100_OUT     = st_reg.spd100;
  assign FULL_DUPLEX_OUT   = st_reg.fdx;
  assign AUTONEG_OUT       = st_reg.autoneg_strap;
  assign REPEATER_MODE_OUT = st_reg.rptr;
  assign POWER_SAVE_OUT    = st_reg.psave;
  assign MIN_POWER_OUT     = st_reg.minp;
  assign NIBBLE_MODE_OUT   = st_reg.nib;
  assign SPARE_TEST_OUT    = st_reg.spare;

  default clocking @(posedge SYS_CLK_IN); endclocking
  default disable iff (!RST_B_IN);

  sequence rd_turn_s;
    st_reg.mst == pss_pkg::MD_RTA && mdc_rise && !isolated;
  endsequence

  ctrl_boot_a: assert property (!st_reg.booted |-> st_reg.ctrl == `PSS_CTRL_RST)
    else $error("control register not at reset value");
  stat_read_a: assert property (rd_turn_s ##0 (st_reg.hdr[4:0] == `PSS_REG_STAT)
    |=> st_reg.shift == `PSS_STAT_RST && MDIO_OE_OUT && !MDIO_OUT)
    else $error("status read wrong");
  id_read_a: assert property (rd_turn_s ##0 (st_reg.hdr[4:0] == `PSS_REG_IDH)
    |=> st_reg.shift == ID_HIGH)
    else $error("identifier read wrong");
  adv_boot_a: assert property (!st_reg.booted |-> st_reg.adv == `PSS_ADV_RST)
    else $error("advertise register not at reset value");
  sni_speed_a: assert property ((SPEED_100_OUT || NIBBLE_MODE_OUT) [*2]
    |-> !CRS_OUT && !LINE_TX_EN_OUT)
    else $error("serial interface active outside 10 Mb/s");
  isolate_a: assert property (isolated [*2] |-> !MDIO_OE_OUT ##1 MIN_POWER_OUT)
    else $error("isolation not honoured");
  txc_rate_a: assert property ($changed(TXC_OUT) |-> $past(st_reg.txdiv) == HALF_M1)
    else $error("transmit clock off rate");
  rx_sample_a: assert property ($rose(RXC_OUT) |-> $past(st_reg.rxph) == HALF_M1)
    else $error("receive clock off centre");
  strap_latch_a: assert property ($rose(st_reg.booted)
    |-> st_reg.phy_addr == $past(st_reg.s2.led))
    else $error("address strap not captured");
  forced_mode_a: assert property (!an_on |=> SPEED_100_OUT == $past(st_reg.ctrl[13]))
    else $error("forced speed not applied");
  test_pin_a: assert property (st_reg.strap.test |=> !REPEATER_MODE_OUT)
    else $error("repeater active in test mode");
endmodule

/* File: test/pss_mac_model.sv */
// serial MAC partner: sends bits against the transmit clock, collects received bits
`timescale 1ns/1ps
module pss_mac_model (
  // serial interface
  input  wire logic txc_in,
  input  wire logic rxc_in,
  input  wire logic rxd0_in,
  input  wire logic crs_in,
  output logic      txen_out,
  output logic      txd0_out
);
  logic rx_q[$];

  initial
  begin
    txen_out = 1'b0;
    txd0_out = 1'b0;
  end

  // bits change as the clock falls and stand across its rise
  task automatic send(input logic [15:0] w);
    for (int i = 15; i >= 0; i--)
    begin
      @(negedge txc_in);
      txen_out <= 1'b1;
      txd0_out <= w[i];
    end
    @(negedge txc_in);
    txen_out <= 1'b0;
    txd0_out <= ~txd0_out;
  endtask

  always @(posedge rxc_in)
    if (crs_in === 1'b1)
      rx_q.push_back(rxd0_in);
endmodule

/* File: test/pss_top_tb_top.sv */
// testbench for the strap, management and serial interface block
`timescale 1ns/1ps
`include "pss_regs.svh"
module pss_top_tb_top;
  localparam int          HALF   = 2;
  localparam logic [15:0] IDH    = 16'h2a5c; // arbitrary value
  localparam logic [15:0] IDL    = 16'h6e31; // arbitrary value
  localparam logic [34:0] OE_WIN = 35'h1ffff0000;
  logic       clk, rst_b, iso, rptr, spd, dup, autoneg_strap, link_down_power_save_strap, ifsel, test_m;
  logic       mdc, mgr_oe, mgr_bit, line_rx, carrier;
  logic [4:0] led_in, pa_flip;
  logic [1:0] seen;
  logic [7:0] b;
  logic [15:0] pat;
  wire        mdio_o, mdio_oe, txc, txen, txd0, rxc, rxd0, crs, col, ltx, ltx_en;
  wire  [4:0] led, led_oe;
  wire        spd100, fdx, aneo, rptro, psave, minp, nib, spare;
  wire        mdio_w = mdio_oe ? mdio_o : (mgr_oe ? mgr_bit : 1'b1);
  logic       tx_q[$];
  int         exp_reg[0:7];
  int         error_cnt, checked, n;

  pss_top #(.TXC_HALF_CYC(HALF), .ID_HIGH(IDH), .ID_LOW(IDL)) DUT (
    .SYS_CLK_IN(clk), .RST_B_IN(rst_b),
    .ISOLATE_STRAP_IN(iso), .REPEATER_STRAP_IN(rptr), .SPEED_STRAP_IN(spd),
    .DUPLEX_STRAP_IN(dup), .AUTONEG_STRAP_IN(autoneg_strap), .LINK_DOWN_POWER_SAVE_STRAP_IN(link_down_power_save_strap),
    .INTERFACE_SELECT_STRAP_IN(ifsel), .TEST_MODE_IN(test_m),
    .MDC_IN(mdc), .MDIO_IN(mdio_w), .MDIO_OUT(mdio_o), .MDIO_OE_OUT(mdio_oe),
    .TXC_OUT(txc), .TXEN_IN(txen), .TXD0_IN(txd0), .RXC_OUT(rxc), .RXD0_OUT(rxd0),
    .CRS_OUT(crs), .COL_OUT(col), .LINE_RX_IN(line_rx), .LINE_CARRIER_IN(carrier),
    .LINE_TX_OUT(ltx), .LINE_TX_EN_OUT(ltx_en), .LED_IN(led_in), .LED_OUT(led),
    .LED_OE_OUT(led_oe), .SPEED_100_OUT(spd100), .FULL_DUPLEX_OUT(fdx),
    .AUTONEG_OUT(aneo), .REPEATER_MODE_OUT(rptro), .POWER_SAVE_OUT(psave),
    .MIN_POWER_OUT(minp), .NIBBLE_MODE_OUT(nib), .SPARE_TEST_OUT(spare)
  );

  pss_mac_model mac (
    .txc_in(txc), .rxc_in(rxc), .rxd0_in(rxd0), .crs_in(crs),
    .txen_out(txen), .txd0_out(txd0)
  );

  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  always @(negedge txc)
    if (ltx_en === 1'b1)
      tx_q.push_back(ltx);

  always @(posedge clk)
  begin
    if (col === 1'b1)
      seen[0] <= 1'b1;
    if (led[4] === 1'b1)
      seen[1] <= 1'b1;
  end

  task automatic cyc(input int k);
    repeat (k) @(negedge clk);
  endtask

  task automatic chk_word(input logic [15:0] got, input logic [15:0] exp, input string what);
    checked++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("ERROR %0t %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic chk_pin(input logic got, input logic exp, input string what);
    checked++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("ERROR %0t %s got %b expected %b", $time, what, got, exp);
    end
  endtask

  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  function automatic bit has(input logic q[$], input logic [15:0] p);
    logic [15:0] w;
    for (int i = 0; i + 16 <= q.size(); i++)
    begin
      for (int j = 0; j < 16; j++)
        w[15 - j] = q[i + j];
      if (w === p)
        return 1'b1;
    end
    return 1'b0;
  endfunction

  // one management frame; the clock stands low between frames
  task automatic mdio(input logic [1:0] op, input logic [4:0] ra, input logic [15:0] wd,
                      output logic [15:0] rd_d, output logic [34:0] oe_s);
    logic [32:0] f;
    logic [34:0] o_s;
    f = {3'b101, op, led_in ^ pa_flip, ra, 2'b10, wd};
    for (int r = 1; r <= 35; r++)
    begin
      mdc = 1'b0;
      mgr_oe = (r <= 15) || (op == `PSS_OP_WRITE && r <= 33);
      mgr_bit = (r <= 33) ? f[33 - r] : 1'b1;
      cyc(4);
      oe_s[r - 1] = mdio_oe;
      o_s[r - 1] = mdio_o;
      mdc = 1'b1;
      cyc(4);
    end
    mdc = 1'b0;
    mgr_oe = 1'b0;
    for (int i = 0; i < 16; i++)
      rd_d[15 - i] = o_s[17 + i];
  endtask

  task automatic rd(input logic [4:0] ra, input logic [15:0] exp);
    logic [15:0] d;
    logic [34:0] w;
    mdio(`PSS_OP_READ, ra, 16'h0000, d, w);
    chk_pin(w === OE_WIN, 1'b1, "read drive window");
    chk_word(d, exp, "read data");
  endtask

  task automatic no_drive(input logic [1:0] op, input logic [4:0] ra, input logic [15:0] wd);
    logic [15:0] d;
    logic [34:0] w;
    mdio(op, ra, wd, d, w);
    chk_pin(|w, 1'b0, "line driven");
  endtask

  task automatic txc_rises(output int k);
    logic p;
    k = 0;
    p = txc;
    repeat (40)
    begin
      cyc(1);
      if (txc === 1'b1 && p === 1'b0)
        k++;
      p = txc;
    end
  endtask

  task automatic boot(input logic [5:0] s);
    rst_b = 1'b0;
    {test_m, rptr, spd, dup, autoneg_strap, link_down_power_save_strap} = s;
    led_in = 5'($urandom);
    cyc(2);
    chk_pin(|{led_oe, spd100, mdio_oe, txc}, 1'b0, "quiet in reset");
    cyc(2);
    rst_b = 1'b1;
    cyc(8);
  endtask

  task automatic chk_modes();
    logic s100;
    s100 = autoneg_strap ? 1'b1 : spd;
    chk_pin(spd100, s100, "speed");
    chk_pin(fdx, autoneg_strap ? 1'b0 : dup, "duplex");
    chk_pin(aneo, autoneg_strap, "autoneg");
    chk_pin(rptro, rptr & ~test_m, "repeater");
    chk_pin(spare, rptr & test_m, "spare test");
    chk_word(16'(led[1:0]), {14'h0000, (autoneg_strap ? 1'b0 : dup), 1'b1}, "link leds");
    chk_pin(psave, link_down_power_save_strap, "power save");
    chk_pin(nib, ifsel, "interface");
    chk_pin(minp, iso, "isolate");
    chk_pin(&led_oe, 1'b1, "led drive");
    txc_rises(n);
    chk_word(16'(n), (!ifsel && !s100) ? 16'd10 : 16'd0, "tx clock");
    rd(`PSS_REG_CTRL, {2'b00, spd, autoneg_strap, 3'b000, dup, 8'h00});
  endtask

  initial
  begin
    {rst_b, iso, rptr, spd, dup, autoneg_strap, link_down_power_save_strap, ifsel, test_m} = '0;
    {mdc, mgr_oe, mgr_bit, line_rx, carrier, led_in, pa_flip, seen} = '0;
    exp_reg = '{0, 16'h7849, IDH, IDL, 16'h01e1, 16'h0080, 0, 0};
    void'($urandom(41379));
    for (int k = 0; k < 6; k++)
    begin
      ifsel = k[0];
      boot((k == 0) ? 6'h1f : 6'($urandom));
      chk_modes();
    end
    // register defaults and access kinds
    ifsel = 1'b0;
    boot(6'h1f);
    for (int a = 1; a < 8; a++)
      rd(5'(a), 16'(exp_reg[a]));
    rd(5'h1f, 16'h0000);
    no_drive(`PSS_OP_WRITE, `PSS_REG_STAT, 16'hffff);
    rd(`PSS_REG_STAT, 16'h7849);
    no_drive(`PSS_OP_WRITE, `PSS_REG_IDH, 16'h0000);
    rd(`PSS_REG_IDH, IDH);
    no_drive(`PSS_OP_WRITE, `PSS_REG_ADV, 16'h0061);
    rd(`PSS_REG_ADV, 16'h0061);
    chk_pin(spd100, 1'b0, "negotiated 10");
    txc_rises(n);
    chk_word(16'(n), 16'd10, "tx clock at 10");
    no_drive(`PSS_OP_WRITE, `PSS_REG_CTRL, 16'h8000);
    cyc(12);
    rd(`PSS_REG_CTRL, 16'h3100);
    rd(`PSS_REG_ADV, 16'h01e1);
    pa_flip = 5'h01;
    no_drive(`PSS_OP_READ, `PSS_REG_STAT, 16'h0000);
    pa_flip = 5'h00;
    iso = 1'b1;
    cyc(4);
    chk_pin(minp, 1'b1, "min power");
    no_drive(`PSS_OP_READ, `PSS_REG_STAT, 16'h0000);
    iso = 1'b0;
    cyc(4);
    // serial path, forced 10 half duplex, carrier during transmit
    boot(6'h00);
    chk_modes();
    b = 8'($urandom);
    tx_q.delete();
    seen = 2'b00;
    carrier = 1'b1;
    mac.send({8'hab, b});
    cyc(1);
    carrier = 1'b0;
    cyc(8);
    chk_pin(has(tx_q, {8'hab, b}), 1'b1, "line transmit");
    chk_word(16'(seen), 16'h0003, "collision and led");
    mac.rx_q.delete();
    b = 8'($urandom);
    pat = {8'hab, b};
    carrier = 1'b1;
    for (int i = 15; i >= 0; i--)
    begin
      line_rx = pat[i];
      cyc(2 * HALF);
    end
    cyc(2 * HALF);
    carrier = 1'b0;
    line_rx = ~line_rx;
    cyc(8);
    chk_pin(has(mac.rx_q, pat), 1'b1, "receive");
    give_verdict();
  end

  initial
  begin
    #5000000;
    error_cnt++;
    $display("ERROR %0t watchdog expired", $time);
    give_verdict();
  end
endmodule
